/* File: include/pss_pkg.sv */
// Shared constants and types for the pipelined synchronous SRAM port
package pss_pkg;
  localparam int unsigned PSS_ADDR_W      = 12;          // Word address width
  localparam int unsigned PSS_LANES       = 2;           // Byte write lanes
  localparam int unsigned PSS_LANE_W      = 9;           // Bits per lane
  localparam int unsigned PSS_DATA_W      = 18;          // Data lane width
  localparam int unsigned PSS_PIPE        = 2;           // Read and write data latency
  localparam int unsigned PSS_FIFO_DEPTH  = 4;           // Request FIFO depth
  localparam logic [1:0]  PSS_BEAT_RESET  = 2'h0;        // Burst beat after reset
  localparam logic [1:0]  PSS_BEATS       = 2'h3;        // Last beat of a burst
  localparam logic        PSS_ORDER_INTERLEAVED = 1'h1;  // Burst order select high
  // Controller request kinds
  typedef enum logic [1:0] {
    PSS_REQ_IDLE  = 2'h0,
    PSS_REQ_READ  = 2'h1,
    PSS_REQ_WRITE = 2'h2
  } pss_req_t;
  // Device operating state, one-hot
  typedef enum logic [2:0] {
    PSS_ST_DESEL  = 3'h1,
    PSS_ST_READ   = 3'h2,
    PSS_ST_WRITE  = 3'h4
  } pss_state_t;
  // Controller request word as carried through the FIFO
  typedef struct packed {
    logic                  burst;   // Continue the current burst
    logic                  write;   // Write when set, read when clear
    logic [PSS_ADDR_W-1:0] addr;    // Start address
    logic [PSS_LANES-1:0]  lane_n;  // Active-low lane enables
    logic [PSS_DATA_W-1:0] data;    // Write data
  } pss_cmd_t;
  localparam int unsigned PSS_CMD_W = $bits(pss_cmd_t);  // Packed request width
endpackage : pss_pkg

/* File: include/pss_if.sv */
// Pin-level link between the SRAM device end and its controller
`timescale 1ns/1ps
interface pss_if;
  import pss_pkg::*;
  logic                  clock_gate_n;         // High stalls the edge
  logic                  advance_or_load;      // High advance, low load
  logic                  read_write;           // High read, low write on load
  logic                  chip_select_first_n;  // Active low select
  logic                  chip_select_second;   // Active high select
  logic                  chip_select_third_n;  // Active low select
  logic [PSS_ADDR_W-1:0] addr;                 // Address, bits 1:0 start the burst
  logic [PSS_LANES-1:0]  byte_write_lane_n;    // Active-low lane enables
  logic                  output_enable_n;      // Asynchronous output enable
  logic                  burst_order_select;   // High interleaved, low linear
  logic                  snooze_request;       // Asynchronous power-down
  logic [PSS_DATA_W-1:0] dq_to_dev;            // Controller drive
  logic                  dq_to_dev_oe;         // Controller drives dq
  logic [PSS_DATA_W-1:0] dq_from_dev;          // Device drive
  logic                  dq_from_dev_oe;       // Device drives dq
  logic [PSS_DATA_W-1:0] dq;                   // Resolved bus level
  logic                  test_clock;           // Boundary scan clock
  logic                  test_mode_select;     // Boundary scan mode
  logic                  test_data_in;         // Boundary scan in
  logic                  test_data_out;        // Boundary scan out
  logic                  test_data_out_oe;     // Boundary scan out enable
  // Resolve the shared data lanes from the two enables
  always_comb begin
    if (dq_from_dev_oe) begin
      dq = dq_from_dev;
    end else if (dq_to_dev_oe) begin
      dq = dq_to_dev;
    end else begin
      dq = '0;
    end
  end
  // Memory end
  modport device (
    input  clock_gate_n, advance_or_load, read_write, chip_select_first_n,
    input  chip_select_second, chip_select_third_n, addr, byte_write_lane_n,
    input  output_enable_n, burst_order_select, snooze_request, dq,
    input  test_clock, test_mode_select, test_data_in,
    output dq_from_dev, dq_from_dev_oe, test_data_out, test_data_out_oe
  );
  // Controller end
  modport controller (
    output clock_gate_n, advance_or_load, read_write, chip_select_first_n,
    output chip_select_second, chip_select_third_n, addr, byte_write_lane_n,
    output output_enable_n, burst_order_select, snooze_request,
    output dq_to_dev, dq_to_dev_oe, test_clock, test_mode_select, test_data_in,
    input  dq
  );
endinterface : pss_if

/* File: design/pss_fifo.sv */
// Small valid/ready FIFO for controller requests
`timescale 1ns/1ps
module pss_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] store [DEPTH];   // Entry storage
  logic [PTR_W-1:0] wr_ptr;          // Next slot to fill
  logic [PTR_W-1:0] rd_ptr;          // Next slot to drain
  logic [PTR_W:0]   count;           // Entries held
  logic             push;            // Accepted write
  logic             pop;             // Accepted read

  assign in_ready  = (count < (PTR_W+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = store[rd_ptr];

  // Storage writes
  always_ff @(posedge clock) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end
endmodule : pss_fifo

/* File: design/pss_device.sv */
// Memory end of the pipelined synchronous SRAM link
//
// What this block does
// - Inputs sampled on clock, except three asynchronous
// - Clock gate high freezes state; snooze and the pin synchronisers still act
// - Address latched only on selected load
// - Drive data only on selected enabled read
// - Chip selects sampled only on load edges
// - Advance steps counter, load takes new address
// - Read/write taken only on load cycles
// - Lane enables gate bytes every write beat
// - Output enable tri-states lanes immediately
// - Order select high interleaved, low linear
// - Scan sampled rising, shifted out falling
// - Snooze keeps deselected, data kept
// - Snooze lasts as long as request high
// - Snooze ignores inputs, outputs high impedance
// - Controller idles before requesting snooze
// - After snooze, controller avoids writes briefly
// - Interleaved address is start xor beat
// - Linear address adds beat modulo four
// - Write data two cycles after command
// - Read data two cycles after command
// - Burst counter wraps every fourth beat
// - Deselect tri-states after two cycle latency
`timescale 1ns/1ps
module pss_device #(
  parameter int unsigned WORDS = 1 << pss_pkg::PSS_ADDR_W
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_b,
  // Link pins
  pss_if.device     link
);
  import pss_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Storage and pipeline state
  logic [PSS_DATA_W-1:0] mem [WORDS];         // Memory array
  pss_state_t            state;                // Burst kind chosen at load
  logic [PSS_ADDR_W-1:0] base;                 // Address loaded at start
  logic [1:0]            beat;                 // Burst beat counter
  logic                  order_interleaved;    // Order captured at load
  logic [PSS_ADDR_W-1:0] cur_addr;             // Address of the next beat
  logic [PSS_PIPE-1:0]   rd_pipe;              // Read slots in flight
  logic [PSS_PIPE-1:0]   wr_pipe;              // Write slots in flight
  logic [PSS_ADDR_W-1:0] addr_pipe [PSS_PIPE]; // Addresses in flight
  logic [PSS_LANES-1:0]  lane_pipe [PSS_PIPE]; // Lane enables in flight
  logic [PSS_DATA_W-1:0] rd_data;              // Read output register
  logic                  rd_drive;             // Read word on output stage
  logic                  zz_s1;                // Snooze synchroniser stage one
  logic                  zz_s2;                // Snooze synchronised
  logic [PSS_DATA_W-1:0] fwd_data;             // Read word with same-edge write
  logic                  order_s1;             // Order select stage one
  logic                  order_s2;             // Order select synchronised
  logic                  selected;             // Select decode at a load
  logic                  edge_on;              // This edge acts
  logic [1:0]            next_beat;            // Beat after an advance
  logic [1:0]            low_bits;             // Beat address low bits

  //////////////////////////////////////////////////////////////////////////
  // Synchronisers for the asynchronous pins
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      zz_s1    <= 1'b0;
      zz_s2    <= 1'b0;
      order_s1 <= PSS_ORDER_INTERLEAVED;
      order_s2 <= PSS_ORDER_INTERLEAVED;
    end else begin
      zz_s1    <= link.snooze_request;
      zz_s2    <= zz_s1;
      order_s1 <= link.burst_order_select;
      order_s2 <= order_s1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Decode of the current edge
  // Edge acts only when not gated; snooze is checked in each process
  assign edge_on  = !link.clock_gate_n ? 1'b1 : 1'b0;
  assign selected = !link.chip_select_first_n && link.chip_select_second
                    && !link.chip_select_third_n;
  assign next_beat = beat + 2'h1;
  // Next beat address: xor for interleaved, add for linear
  always_comb begin
    if (order_interleaved) begin
      low_bits = base[1:0] ^ next_beat;
    end else begin
      low_bits = base[1:0] + next_beat;
    end
  end
  assign cur_addr = {base[PSS_ADDR_W-1:2], low_bits};

  //////////////////////////////////////////////////////////////////////////
  // Load and burst control
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state             <= PSS_ST_DESEL;
      base              <= '0;
      beat              <= PSS_BEAT_RESET;
      order_interleaved <= PSS_ORDER_INTERLEAVED;
    end else if (zz_s2) begin
      state <= PSS_ST_DESEL;
    end else if (edge_on) begin
      if (!link.advance_or_load) begin
        if (selected) begin
          base              <= link.addr;
          beat              <= PSS_BEAT_RESET;
          order_interleaved <= order_s2;
          state <= link.read_write ? PSS_ST_READ : PSS_ST_WRITE;
        end else begin
          state <= PSS_ST_DESEL;
        end
      end else if (state != PSS_ST_DESEL) begin
        beat <= next_beat;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Two-stage pipeline of beats toward the data lanes
  // Slot zero holds the beat taken on this edge
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_pipe <= '0;
      wr_pipe <= '0;
      for (int i = 0; i < PSS_PIPE; i++) begin
        addr_pipe[i] <= '0;
        lane_pipe[i] <= '1;
      end
    end else if (zz_s2) begin
      rd_pipe <= '0;
      wr_pipe <= '0;
    end else if (edge_on) begin
      // Beat active for this edge, by the post-edge state
      rd_pipe[0] <= (!link.advance_or_load && selected && link.read_write)
                    || (link.advance_or_load && state == PSS_ST_READ);
      wr_pipe[0] <= (!link.advance_or_load && selected && !link.read_write)
                    || (link.advance_or_load && state == PSS_ST_WRITE);
      addr_pipe[0] <= !link.advance_or_load ? link.addr : cur_addr;
      lane_pipe[0] <= link.byte_write_lane_n;
      for (int i = 1; i < PSS_PIPE; i++) begin
        rd_pipe[i]   <= rd_pipe[i-1];
        wr_pipe[i]   <= wr_pipe[i-1];
        addr_pipe[i] <= addr_pipe[i-1];
        lane_pipe[i] <= lane_pipe[i-1];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Memory writes two edges after the command, lane by lane
  // One process owns the array, so it has a single driver
  always_ff @(posedge clock) begin
    if (!zz_s2 && edge_on && wr_pipe[PSS_PIPE-1]) begin
      for (int l = 0; l < PSS_LANES; l++) begin
        if (!lane_pipe[PSS_PIPE-1][l]) begin
          mem[addr_pipe[PSS_PIPE-1]][l*PSS_LANE_W +: PSS_LANE_W]
            <= link.dq[l*PSS_LANE_W +: PSS_LANE_W];
        end
      end
    end
  end

  // Read word, with lanes that the write of this edge replaces
  always_comb begin
    fwd_data = mem[addr_pipe[PSS_PIPE-2]];
    for (int l = 0; l < PSS_LANES; l++) begin
      if (wr_pipe[PSS_PIPE-1] && !lane_pipe[PSS_PIPE-1][l]
          && addr_pipe[PSS_PIPE-1] == addr_pipe[PSS_PIPE-2]) begin
        fwd_data[l*PSS_LANE_W +: PSS_LANE_W] = link.dq[l*PSS_LANE_W +: PSS_LANE_W];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read output register, held while the clock is gated
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_data  <= '0;
      rd_drive <= 1'b0;
    end else if (zz_s2) begin
      rd_drive <= 1'b0;
    end else if (edge_on) begin
      rd_drive <= rd_pipe[PSS_PIPE-2];
      rd_data  <= fwd_data;
    end
  end

  // Lane drive: read slot valid, enabled, not snoozing
  assign link.dq_from_dev    = rd_data;
  assign link.dq_from_dev_oe = rd_drive && !link.output_enable_n
                               && !link.snooze_request;

  //////////////////////////////////////////////////////////////////////////
  // Boundary scan: bypass cell, in on rising, out on falling
  logic scan_cell;  // Bypass bit
  logic scan_out;   // Falling-edge output stage
  always_ff @(posedge link.test_clock or negedge rst_b) begin
    if (!rst_b) begin
      scan_cell <= 1'b0;
    end else if (!link.test_mode_select) begin
      scan_cell <= link.test_data_in;
    end
  end
  always_ff @(negedge link.test_clock or negedge rst_b) begin
    if (!rst_b) begin
      scan_out <= 1'b0;
    end else begin
      scan_out <= scan_cell;
    end
  end
  assign link.test_data_out    = scan_out;
  assign link.test_data_out_oe = !link.snooze_request;
endmodule : pss_device

/* File: design/pss_controller.sv */
// Controller end: queues requests and drives the SRAM pins
`timescale 1ns/1ps
module pss_controller (
  // Clock and reset
  input  wire logic                          clock,
  input  wire logic                          rst_b,
  // Request side
  input  wire logic                          req_valid,
  output logic                               req_ready,
  input  wire pss_pkg::pss_cmd_t             req_cmd,
  // Read answers
  output logic                               rsp_valid,
  output logic [pss_pkg::PSS_DATA_W-1:0]     rsp_data,
  // Static and power controls
  input  wire logic                          order_linear,
  input  wire logic                          snooze,
  output logic                               snooze_active,
  // Link pins
  pss_if.controller                          link
);
  import pss_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Request queue
  logic     q_valid;                // Queued request present
  logic     q_ready;                // Pin stage takes it
  pss_cmd_t q_cmd;                  // Head request
  logic [PSS_CMD_W-1:0] q_bits;     // Head as bits
  logic [PSS_PIPE:0]    rd_pend;    // Read beats in flight
  logic [PSS_PIPE:0]    wr_pend;    // Write beats in flight
  logic [PSS_DATA_W-1:0] wd_pipe [PSS_PIPE];  // Write data in flight
  logic     busy;                   // Any beat in flight
  logic     snooze_ok;              // Safe to enter snooze
  logic     exit_wait;              // Writes held after snooze
  logic     wake;                   // Device synchroniser still clearing
  logic     issue;                  // Request issued this edge

  pss_fifo #(.WIDTH(PSS_CMD_W), .DEPTH(PSS_FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .rst_b     (rst_b),
    .in_valid  (req_valid),
    .in_ready  (req_ready),
    .in_data   (req_cmd),
    .out_valid (q_valid),
    .out_ready (q_ready),
    .out_data  (q_bits)
  );
  assign q_cmd = pss_cmd_t'(q_bits);

  //////////////////////////////////////////////////////////////////////////
  // Issue control
  assign busy      = (rd_pend != '0) || (wr_pend != '0);
  assign snooze_ok = snooze && !busy && !q_valid;
  // Hold all while snoozing or waking, writes while leaving
  assign q_ready   = !snooze_active && !wake && !(exit_wait && q_cmd.write);
  assign issue     = q_valid && q_ready;

  // Snooze state and exit window of one pipeline depth
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      snooze_active <= 1'b0;
      exit_wait     <= 1'b0;
      wake          <= 1'b0;
    end else begin
      wake <= snooze_active;
      if (snooze_ok) begin
        snooze_active <= 1'b1;
      end else if (!snooze && snooze_active) begin
        exit_wait     <= 1'b1;
        snooze_active <= 1'b0;
      end
      // Window ends when queue empties or nothing is in flight
      if (!snooze_active && !wake && (!q_valid || !busy)) begin
        exit_wait <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin drive, registered
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      link.advance_or_load     <= 1'b0;
      link.read_write          <= 1'b1;
      link.chip_select_first_n <= 1'b1;
      link.chip_select_second  <= 1'b0;
      link.chip_select_third_n <= 1'b1;
      link.addr                <= '0;
      link.byte_write_lane_n   <= '1;
    end else begin
      link.advance_or_load     <= issue && q_cmd.burst;
      link.read_write          <= !(issue && q_cmd.write);
      link.chip_select_first_n <= !issue;
      link.chip_select_second  <= issue;
      link.chip_select_third_n <= !issue;
      link.addr                <= q_cmd.addr;
      link.byte_write_lane_n   <= (issue && q_cmd.write) ? q_cmd.lane_n : '1;
    end
  end

  // Write data and answer tracking, two cycles deep
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_pend <= '0;
      wr_pend <= '0;
      for (int i = 0; i < PSS_PIPE; i++) begin
        wd_pipe[i] <= '0;
      end
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
      link.dq_to_dev    <= '0;
      link.dq_to_dev_oe <= 1'b0;
    end else begin
      rd_pend <= {rd_pend[PSS_PIPE-1:0], issue && !q_cmd.write};
      wr_pend <= {wr_pend[PSS_PIPE-1:0], issue && q_cmd.write};
      wd_pipe[0] <= q_cmd.data;
      for (int i = 1; i < PSS_PIPE; i++) begin
        wd_pipe[i] <= wd_pipe[i-1];
      end
      link.dq_to_dev    <= wd_pipe[PSS_PIPE-1];
      link.dq_to_dev_oe <= wr_pend[PSS_PIPE-1];
      rsp_valid <= rd_pend[PSS_PIPE];
      rsp_data  <= link.dq;
    end
  end

  // Static and power pins
  assign link.clock_gate_n       = 1'b0;
  assign link.output_enable_n    = 1'b0;
  assign link.burst_order_select = !order_linear;
  assign link.snooze_request     = snooze_active;
  assign link.test_clock         = 1'b0;
  assign link.test_mode_select   = 1'b1;
  assign link.test_data_in       = 1'b0;
endmodule : pss_controller

/* File: testbench/pss_link_checker.sv */
// Pin-level checker for the SRAM link
`timescale 1ns/1ps
module pss_link_checker (
  // Clock and reset
  input wire logic       clock,
  input wire logic       rst_b,
  // Link pins
  input wire logic       advance_or_load,
  input wire logic       read_write,
  input wire logic       chip_select_first_n,
  input wire logic       chip_select_second,
  input wire logic       chip_select_third_n,
  input wire logic [1:0] byte_write_lane_n,
  input wire logic       output_enable_n,
  input wire logic       snooze_request,
  input wire logic       dq_to_dev_oe,
  input wire logic       dq_from_dev_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////
  // Selected and deselected load edges
  logic sel_ld;  // Selected load
  logic des_ld;  // Deselecting load
  assign sel_ld = !advance_or_load && !chip_select_first_n && chip_select_second
                  && !chip_select_third_n;
  assign des_ld = !advance_or_load && !sel_ld;
  ////////////////////////////////////////////////////////////////
  chk_oe_off: assert property (output_enable_n |-> !dq_from_dev_oe)
    else $error("data driven while output enable off");
  chk_snooze_hiz: assert property (snooze_request |-> !dq_from_dev_oe)
    else $error("data driven in snooze");
  chk_no_clash: assert property (!(dq_to_dev_oe && dq_from_dev_oe))
    else $error("both ends drive data");
  chk_read_lat: assert property (sel_ld && read_write && !output_enable_n
    && !snooze_request |-> ##2 dq_from_dev_oe) else $error("read data late");
  chk_write_lat: assert property (sel_ld && !read_write && byte_write_lane_n != 2'h3
    |-> ##2 dq_to_dev_oe) else $error("write data not two cycles on");
  chk_desel_hiz: assert property (des_ld |-> ##2 !dq_from_dev_oe)
    else $error("deselect left data driven");
  chk_desel_nowr: assert property (des_ld |-> ##2 !dq_to_dev_oe)
    else $error("write data after deselect");
  chk_snooze_idle: assert property ($rose(snooze_request) |-> !dq_to_dev_oe
    && !dq_from_dev_oe) else $error("snooze with transfer in flight");
  chk_snooze_nold: assert property (snooze_request |-> !sel_ld)
    else $error("access issued in snooze");
  // Main scenarios reached
  cov_read: cover property (sel_ld && read_write);
  cov_write: cover property (sel_ld && !read_write);
  cov_snooze: cover property ($fell(snooze_request));
endmodule : pss_link_checker

/* File: testbench/pipelined_sync_sram_port_tb_top.sv */
// Self-checking bench for the controller and device pair
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module pipelined_sync_sram_port_tb_top;
  import pss_pkg::*;
  logic                  clock = 1'b0;         // System clock
  logic                  rst_b = 1'b0;         // Reset, active low
  logic                  req_valid = 1'b0;     // Request offered
  logic                  req_ready;            // Queue has room
  pss_cmd_t              req_cmd = '0;         // Request word
  logic                  rsp_valid;            // Read answer strobe
  logic [PSS_DATA_W-1:0] rsp_data;             // Read answer
  logic                  order_linear = 1'b0;  // Burst order
  logic                  snooze = 1'b0;        // Power-down request
  logic                  snooze_active;        // Power-down reached
  int                    n_errors = 0;         // Mismatches
  int                    compares = 0;         // Comparisons
  logic [PSS_DATA_W-1:0] mem [int];            // Expected contents
  logic [PSS_DATA_W-1:0] exp_q [$];            // Expected answers
  logic [PSS_DATA_W-1:0] e;                    // Oldest expectation
  logic [PSS_ADDR_W-1:0] a;                    // Test address
  logic [PSS_ADDR_W-1:0] base;                 // Burst start
  logic [PSS_ADDR_W-1:0] eff;                  // Beat address
  logic [1:0]            k;                    // Beat count
  always #20 clock = ~clock;
  pss_if pss_if_i ();
  pss_device pss_device_i (.clock(clock), .rst_b(rst_b), .link(pss_if_i));
  pss_controller pss_controller_i (.clock(clock), .rst_b(rst_b), .req_valid(req_valid),
    .req_ready(req_ready), .req_cmd(req_cmd), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .order_linear(order_linear), .snooze(snooze), .snooze_active(snooze_active),
    .link(pss_if_i));
  pss_link_checker pss_link_checker_i (.clock(clock), .rst_b(rst_b),
    .advance_or_load(pss_if_i.advance_or_load), .read_write(pss_if_i.read_write),
    .chip_select_first_n(pss_if_i.chip_select_first_n),
    .chip_select_second(pss_if_i.chip_select_second),
    .chip_select_third_n(pss_if_i.chip_select_third_n),
    .byte_write_lane_n(pss_if_i.byte_write_lane_n),
    .output_enable_n(pss_if_i.output_enable_n), .snooze_request(pss_if_i.snooze_request),
    .dq_to_dev_oe(pss_if_i.dq_to_dev_oe), .dq_from_dev_oe(pss_if_i.dq_from_dev_oe));
  ////////////////////////////////////////////////////////////////
  // Monitor: each answer against the oldest note
  always @(negedge clock) begin
    if (rsp_valid === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
      `CHK(rsp_data, e)
    end
  end
  // Offer one request, noting its expected effect; leaves it offered
  task automatic push(input logic b, input logic w, input logic [PSS_ADDR_W-1:0] ad,
                      input logic [1:0] ln, input logic [PSS_DATA_W-1:0] dt);
    int t;
    t = 0;
    if (!b) begin
      base = ad;
      k = 2'h0;
    end else begin
      k = k + 2'h1;  // Wraps every fourth beat
    end
    eff = {base[PSS_ADDR_W-1:2], order_linear ? base[1:0] + k : base[1:0] ^ k};
    if (w && !ln[0]) mem[eff][8:0] = dt[8:0];
    if (w && !ln[1]) mem[eff][17:9] = dt[17:9];
    if (!w) exp_q.push_back(mem[eff]);
    req_cmd = '{burst: b, write: w, addr: ad, lane_n: ln, data: dt};
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && t < 300) begin
      @(negedge clock);
      t++;
    end
    if (t == 300) n_errors++;  // Request never taken
    @(negedge clock);
  endtask : push
  // Stop offering and wait for all answers
  task automatic drain(input string name);
    req_valid = 1'b0;
    for (int t = 0; t < 100 && exp_q.size() > 0; t++) @(negedge clock);
    repeat (4) @(negedge clock);
    `CHK(exp_q.size(), 0)
    $display("test %s done", name);
  endtask : drain
  // Print counts and verdict, then stop
  task automatic results();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    #(40 * 20000);
    n_errors++;
    results();
  end
  // Main sequence
  initial begin
    void'($urandom(32'hd511));
    repeat (3) @(negedge clock);
    rst_b = 1'b1;
    @(negedge clock);
    // Lane masks including abort, mixed back to back
    a = PSS_ADDR_W'($urandom);
    push(1'b0, 1'b1, a, 2'h0, PSS_DATA_W'($urandom));
    for (int ln = 0; ln < 4; ln++) begin
      push(1'b0, 1'b1, a, 2'(ln), PSS_DATA_W'($urandom));
      push(1'b0, 1'b0, a, 2'h0, '0);
    end
    drain("lanes");
    // Five-beat write bursts in both orders, read back singly and as a burst
    for (int o = 0; o < 2; o++) begin
      order_linear = o[0];
      repeat (4) @(negedge clock);  // Static setting: let it pass the pin synchroniser
      for (int s = 0; s < 4; s++) begin
        a = {(PSS_ADDR_W-2)'($urandom), 2'(s)};
        for (int j = 0; j < 5; j++) push(j > 0, 1'b1, a, 2'h0, PSS_DATA_W'($urandom));
        for (int j = 0; j < 4; j++) push(1'b0, 1'b0, {a[PSS_ADDR_W-1:2], 2'(j)}, 2'h0, '0);
        for (int j = 0; j < 4; j++) push(j > 0, 1'b0, a, 2'h0, '0);
      end
      drain("burst");
    end
    // Snooze: queue fills, refuses, then drains with reads only
    snooze = 1'b1;
    for (int t = 0; t < 50 && snooze_active !== 1'b1; t++) @(negedge clock);
    `CHK(snooze_active, 1'b1)
    for (int j = 0; j < 4; j++) push(1'b0, 1'b0, {a[PSS_ADDR_W-1:2], 2'(j)}, 2'h0, '0);
    repeat (3) @(negedge clock);
    `CHK(req_ready, 1'b0)
    fork
      push(1'b0, 1'b0, a, 2'h0, '0);
      begin
        repeat (4) @(negedge clock);
        snooze = 1'b0;
      end
    join
    drain("snooze");
    results();
  end
endmodule : pipelined_sync_sram_port_tb_top
